// ---- pkg/lgc_pkg.sv ----
package lgc_pkg;

  localparam int unsigned NUM_CH       = 8;
  localparam int unsigned REG_W        = 8;

  // Printed offsets are not all multiples of four, so they are word indexes.
  localparam logic [7:0]  IDX_AUTO_AO  = 8'h0E;
  localparam logic [7:0]  IDX_GLOBAL   = 8'h0F;
  localparam logic [7:0]  IDX_LL_SEL   = 8'h10;
  localparam logic [7:0]  IDX_LL_DATA  = 8'h11;
  localparam logic [7:0]  IDX_PH_ADDR  = 8'h17;
  localparam logic [7:0]  IDX_PH_DATA  = 8'h18;

  localparam logic [7:0]  RST_AUTO_AO  = 8'h00;
  localparam logic [7:0]  RST_GLOBAL   = 8'h00;
  localparam logic [7:0]  RST_LL_SEL   = 8'h00;
  localparam logic [7:0]  RST_LL_DATA  = 8'h00;
  localparam logic [7:0]  RST_PH_ADDR  = 8'h00;

  localparam int unsigned GC_AUTO_INC  = 7;
  localparam int unsigned GC_RX_AIS    = 6;
  localparam int unsigned GC_RSVD      = 5;
  localparam int unsigned GC_CODE      = 4;
  localparam int unsigned GC_FIFO      = 3;
  localparam int unsigned GC_CORNER    = 2;
  localparam int unsigned GC_POS_HI    = 1;
  localparam int unsigned GC_POS_LO    = 0;

  localparam int unsigned LL_ID_HI     = 2;
  localparam int unsigned PH_SAMPLE_W  = 5;

  localparam logic [6:0]  FIFO_DEPTH_SHORT = 7'h20;
  localparam logic [6:0]  FIFO_DEPTH_LONG  = 7'h40;

  typedef enum logic [1:0] {
    LGC_JA_OFF_A = 2'h0,
    LGC_JA_TX    = 2'h1,
    LGC_JA_OFF_B = 2'h2,
    LGC_JA_RX    = 2'h3
  } lgc_ja_pos_e;

  typedef enum logic {
    LGC_CODE_ZS  = 1'h0,
    LGC_CODE_AMI = 1'h1
  } lgc_code_e;

  function automatic logic [7:0] lgc_word_index(input logic [11:0] paddr);
    lgc_word_index = paddr[9:2];
  endfunction : lgc_word_index

endpackage : lgc_pkg

// ---- pkg/lgc_cfg_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface lgc_cfg_if;
  import lgc_pkg::*;
  logic [7:0] auto_ao;
  logic [7:0] global_ctl;
  logic [7:0] ll_sel;
  modport src (output auto_ao, output global_ctl, output ll_sel);
  modport dst (input auto_ao, input global_ctl, input ll_sel);
endinterface : lgc_cfg_if
`default_nettype wire

// ---- src/lgc_ll_store.sv ----
`timescale 1ns/1ns
`default_nettype none
// Per-channel line-length data, addressed by the channel id.
module lgc_ll_store (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // Access
  input  wire logic [2:0] chan,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  import lgc_pkg::*;

  logic [7:0] mem_q [NUM_CH];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        mem_q[i] <= RST_LL_DATA;
      end
    end else if (clk_en && wr) begin
      mem_q[chan] <= wdata;
    end
  end

  assign rdata = mem_q[chan];

endmodule : lgc_ll_store
`default_nettype wire

// ---- src/lgc_chan_ctl.sv ----
`timescale 1ns/1ns
`default_nettype none
// Per-channel loss-of-signal actions driven by the auto all-ones mask and the global settings.
module lgc_chan_ctl (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       clk_en,
  // Configuration
  lgc_cfg_if.dst          cfg,
  // Receiver status
  input  wire logic [7:0] los_in,
  // Actions
  output logic      [7:0] tx_all_ones,
  output logic      [7:0] rx_ais_insert
);
  import lgc_pkg::*;

  logic [7:0] los_q;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      los_q <= 8'h00;
    end else if (clk_en) begin
      los_q <= los_in;
    end
  end

  assign tx_all_ones   = los_q & cfg.auto_ao;
  assign rx_ais_insert = los_q & {NUM_CH{cfg.global_ctl[GC_RX_AIS]}};

endmodule : lgc_chan_ctl
`default_nettype wire

// ---- src/lgc_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
module lgc_regs (
  // Clock, enable and reset
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Receiver status
  input  wire logic [7:0]  los_in,
  // Channel actions
  output logic      [7:0]  tx_all_ones,
  output logic      [7:0]  rx_ais_insert,
  // Global and line-length channel settings to the datapaths
  output lgc_pkg::lgc_code_e   line_code_select,
  output logic      [6:0]  jitter_fifo_depth,
  output logic             jitter_corner_select,
  output logic             ja_in_tx,
  output logic             ja_in_rx,
  output logic      [7:0]  ll_chan_onehot,
  // Waveform generator data port
  output logic      [7:0]  ph_addr,
  output logic             ph_access
);
  import lgc_pkg::*;

  lgc_cfg_if cfg ();

  logic [7:0]  auto_ao_q;
  logic [7:0]  global_q;
  logic [7:0]  ll_sel_q;
  logic [7:0]  ph_addr_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [7:0]  tx_ao_q;
  logic [7:0]  rx_ais_q;
  logic        code_q;
  logic [6:0]  depth_q;
  logic        corner_q;
  logic        ja_tx_q;
  logic        ja_rx_q;
  logic [7:0]  onehot_q;
  logic        ph_acc_q;

  logic [7:0]  idx;
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [7:0]  rd_d;
  logic [7:0]  ll_rdata;
  logic [7:0]  tx_ao_d;
  logic [7:0]  rx_ais_d;
  logic        ll_wr;
  logic        ph_hit;

  assign cfg.auto_ao    = auto_ao_q;
  assign cfg.global_ctl = global_q;
  assign cfg.ll_sel     = ll_sel_q;

  // A request is taken in the first access cycle; the answer comes one cycle later.
  assign idx    = lgc_word_index(paddr);
  assign acc    = psel && penable && !pready_q;
  assign wr     = acc && pwrite;
  assign ll_wr  = wr && mapped && (idx == IDX_LL_DATA);
  assign ph_hit = acc && mapped && (idx == IDX_PH_DATA);

  always_comb begin
    mapped = 1'b1;
    rd_d   = 8'h00;
    case (idx)
      IDX_AUTO_AO: rd_d = auto_ao_q;
      IDX_GLOBAL:  rd_d = global_q;
      IDX_LL_SEL:  rd_d = ll_sel_q;
      IDX_LL_DATA: rd_d = ll_rdata;
      IDX_PH_ADDR: rd_d = ph_addr_q;
      IDX_PH_DATA: rd_d = 8'h00;
      default:     mapped = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0 || paddr[11:10] != 2'h0) begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      if (acc && !pwrite) begin
        prdata_q <= {24'h00_0000, rd_d};
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      auto_ao_q <= RST_AUTO_AO;
    end else if (clk_en && wr && mapped && idx == IDX_AUTO_AO) begin
      auto_ao_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      global_q <= RST_GLOBAL;
    end else if (clk_en && wr && mapped && idx == IDX_GLOBAL) begin
      global_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ll_sel_q <= RST_LL_SEL;
    end else if (clk_en && wr && mapped && idx == IDX_LL_SEL) begin
      ll_sel_q <= pwdata[7:0];
    end
  end

  // Auto-increment wraps within the phase-sample field and keeps the upper bits.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ph_addr_q <= RST_PH_ADDR;
    end else if (clk_en) begin
      if (wr && mapped && idx == IDX_PH_ADDR) begin
        ph_addr_q <= pwdata[7:0];
      end else if (ph_hit && global_q[GC_AUTO_INC]) begin
        ph_addr_q[PH_SAMPLE_W-1:0] <= ph_addr_q[PH_SAMPLE_W-1:0] + 5'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ph_acc_q <= 1'b0;
    end else if (clk_en) begin
      ph_acc_q <= ph_hit;
    end
  end

  lgc_ll_store u_store (
    .clock   (clock),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .chan    (ll_sel_q[LL_ID_HI:0]),
    .wr      (ll_wr),
    .wdata   (pwdata[7:0]),
    .rdata   (ll_rdata)
  );

  lgc_chan_ctl u_chan (
    .clock         (clock),
    .reset_n       (reset_n),
    .clk_en        (clk_en),
    .cfg           (cfg),
    .los_in        (los_in),
    .tx_all_ones   (tx_ao_d),
    .rx_ais_insert (rx_ais_d)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tx_ao_q  <= 8'h00;
      rx_ais_q <= 8'h00;
    end else if (clk_en) begin
      tx_ao_q  <= tx_ao_d;
      rx_ais_q <= rx_ais_d;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      code_q   <= 1'b0;
      depth_q  <= FIFO_DEPTH_SHORT;
      corner_q <= 1'b0;
      ja_tx_q  <= 1'b0;
      ja_rx_q  <= 1'b0;
      onehot_q <= 8'h01;
    end else if (clk_en) begin
      code_q   <= global_q[GC_CODE];
      depth_q  <= global_q[GC_FIFO] ? FIFO_DEPTH_LONG : FIFO_DEPTH_SHORT;
      corner_q <= global_q[GC_CORNER];
      case (lgc_ja_pos_e'(global_q[GC_POS_HI:GC_POS_LO]))
        LGC_JA_TX: begin
          ja_tx_q <= 1'b1;
          ja_rx_q <= 1'b0;
        end
        LGC_JA_RX: begin
          ja_tx_q <= 1'b0;
          ja_rx_q <= 1'b1;
        end
        default: begin
          ja_tx_q <= 1'b0;
          ja_rx_q <= 1'b0;
        end
      endcase
      onehot_q <= 8'h01 << ll_sel_q[LL_ID_HI:0];
    end
  end

  assign prdata               = prdata_q;
  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign tx_all_ones          = tx_ao_q;
  assign rx_ais_insert        = rx_ais_q;
  assign line_code_select     = lgc_code_e'(code_q);
  assign jitter_fifo_depth    = depth_q;
  assign jitter_corner_select = corner_q;
  assign ja_in_tx             = ja_tx_q;
  assign ja_in_rx             = ja_rx_q;
  assign ll_chan_onehot       = onehot_q;
  assign ph_addr              = ph_addr_q;
  assign ph_access            = ph_acc_q;

endmodule : lgc_regs
`default_nettype wire

// ---- tb/lgc_regs_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module lgc_regs_sva (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset_n,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Channel side
  input wire logic [7:0]  los_in,
  input wire logic [7:0]  tx_all_ones,
  input wire logic [7:0]  rx_ais_insert,
  input wire logic [6:0]  jitter_fifo_depth,
  input wire logic        ja_in_tx,
  input wire logic        ja_in_rx,
  input wire logic [7:0]  ll_chan_onehot,
  input wire logic        ph_access
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_ao; (tx_all_ones & ~$past(los_in, 2)) == 8'h00; endproperty
  a_ao: assert property (p_ao) else $error("all-ones without loss");
  property p_ais; rx_ais_insert == 8'h00 || rx_ais_insert == $past(los_in, 2); endproperty
  a_ais: assert property (p_ais) else $error("alarm not uniform");
  property p_ja; !(ja_in_tx && ja_in_rx); endproperty
  a_ja: assert property (p_ja) else $error("attenuator in both paths");
  property p_fifo; jitter_fifo_depth == 7'h20 || jitter_fifo_depth == 7'h40; endproperty
  a_fifo: assert property (p_fifo) else $error("bad fifo depth");
  property p_oh; $onehot(ll_chan_onehot); endproperty
  a_oh: assert property (p_oh) else $error("channel select not one-hot");
  property p_take; psel && penable && !pready |=> pready ##1 !pready; endproperty
  a_take: assert property (p_take) else $error("answer timing");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_ph; psel && penable && !pready && paddr == 12'h060 |=> ph_access; endproperty
  a_ph: assert property (p_ph) else $error("no phase access pulse");
endmodule : lgc_regs_sva
bind lgc_regs lgc_regs_sva u_sva (.clock(clock), .reset_n(reset_n), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .los_in(los_in), .tx_all_ones(tx_all_ones), .rx_ais_insert(rx_ais_insert),
  .jitter_fifo_depth(jitter_fifo_depth), .ja_in_tx(ja_in_tx), .ja_in_rx(ja_in_rx),
  .ll_chan_onehot(ll_chan_onehot), .ph_access(ph_access));
`default_nettype wire

// ---- tb/lgc_regs_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module lgc_regs_bench;
  import lgc_pkg::*;
  logic        clock = 0, reset_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, corner, ja_tx, ja_rx, ph_acc, err, pha;
  logic [7:0]  los_in = 8'h00, tx_ao, rx_ais, ll_oh, ph_addr;
  logic [6:0]  fifo_d;
  logic [1:0]  j;
  lgc_code_e   code;
  int          mismatches = 0, checks_done = 0;
  always #10 clock = ~clock;
  lgc_regs dut (.clock(clock), .reset_n(reset_n), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .los_in(los_in), .tx_all_ones(tx_ao),
    .rx_ais_insert(rx_ais), .line_code_select(code), .jitter_fifo_depth(fifo_d),
    .jitter_corner_select(corner), .ja_in_tx(ja_tx), .ja_in_rx(ja_rx),
    .ll_chan_onehot(ll_oh), .ph_addr(ph_addr), .ph_access(ph_acc));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) chk("pready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    pha = ph_acc;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic t_reset;
    chk("fifo", 32'h20, {25'h0, fifo_d});
    chk("onehot", 32'h1, {24'h0, ll_oh});
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 12'h038 + 12'(4 * i), 32'h0);
      chk("reset value", 32'h0, rd);
    end
  endtask : t_reset
  task automatic t_ao;
    apb(1'b1, 12'h038, 32'hA5);
    los_in <= 8'hFF;
    repeat (4) @(posedge clock);
    chk("tx_ao", 32'hA5, {24'h0, tx_ao});
    chk("rx_ais off", 32'h0, {24'h0, rx_ais});
    apb(1'b1, 12'h03C, 32'h40);
    repeat (4) @(posedge clock);
    chk("rx_ais on", 32'hFF, {24'h0, rx_ais});
    los_in <= 8'h00;
    repeat (4) @(posedge clock);
    chk("tx_ao idle", 32'h0, {24'h0, tx_ao});
    chk("rx_ais idle", 32'h0, {24'h0, rx_ais});
    clk_en <= 1'b0;
    los_in <= 8'hFF;
    repeat (4) @(posedge clock);
    chk("tx_ao frozen", 32'h0, {24'h0, tx_ao});
    clk_en <= 1'b1;
    repeat (4) @(posedge clock);
    chk("tx_ao resumed", 32'hA5, {24'h0, tx_ao});
    chk("rx_ais resumed", 32'hFF, {24'h0, rx_ais});
    los_in <= 8'h00;
    repeat (4) @(posedge clock);
  endtask : t_ao
  task automatic t_gc;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      j = 2'(i);
      v = {3'b000, j[0], j[1], j[0], j};
      apb(1'b1, 12'h03C, {24'h0, v});
      apb(1'b0, 12'h03C, 32'h0);
      chk("global", {24'h0, v}, rd);
      repeat (3) @(posedge clock);
      chk("code", {31'h0, j[0]}, {31'h0, code});
      chk("fifo", j[1] ? 32'h40 : 32'h20, {25'h0, fifo_d});
      chk("corner", {31'h0, j[0]}, {31'h0, corner});
      chk("ja", {30'h0, j == 2'h3, j == 2'h1}, {30'h0, ja_rx, ja_tx});
    end
  endtask : t_gc
  task automatic t_ll;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h040, 32'(i));
      apb(1'b1, 12'h044, 32'h50 + 32'(i));
      repeat (3) @(posedge clock);
      chk("onehot", 32'h1 << i, {24'h0, ll_oh});
    end
    for (int i = 7; i >= 0; i--) begin
      apb(1'b1, 12'h040, 32'(i));
      apb(1'b0, 12'h044, 32'h0);
      chk("ll data", 32'h50 + 32'(i), rd);
    end
  endtask : t_ll
  task automatic t_ph;
    apb(1'b1, 12'h03C, 32'h80);
    apb(1'b1, 12'h05C, 32'hFF);
    apb(1'b0, 12'h060, 32'h0);
    chk("ph_access", 32'h1, {31'h0, pha});
    repeat (2) @(posedge clock);
    chk("ph wrap", 32'hE0, {24'h0, ph_addr});
    apb(1'b1, 12'h060, 32'h0);
    repeat (2) @(posedge clock);
    chk("ph step", 32'hE1, {24'h0, ph_addr});
    apb(1'b1, 12'h03C, 32'h00);
    apb(1'b0, 12'h060, 32'h0);
    repeat (2) @(posedge clock);
    chk("ph hold", 32'hE1, {24'h0, ph_addr});
  endtask : t_ph
  task automatic t_err;
    apb(1'b1, 12'h03E, 32'hFF);
    chk("slverr", 32'h1, {31'h0, err});
    apb(1'b0, 12'h03C, 32'h0);
    chk("global kept", 32'h0, rd);
    chk("slverr clear", 32'h0, {31'h0, err});
  endtask : t_err
  task automatic t_rst2;
    apb(1'b1, 12'h038, 32'hFF);
    apb(1'b1, 12'h03C, 32'h1F);
    apb(1'b1, 12'h040, 32'h07);
    apb(1'b1, 12'h044, 32'h3C);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    apb(1'b0, 12'h044, 32'h0);
    chk("ll data reset", 32'h0, rd);
  endtask : t_rst2
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_ao();
    t_gc();
    t_ll();
    t_ph();
    t_err();
    t_rst2();
    end_sim();
  end
  initial begin
    #200000;
    mismatches++;
    end_sim();
  end
endmodule : lgc_regs_bench
`default_nettype wire
